// ---- verilog/hfa_defines.svh ----
// constants of the heading filter acquisition block
//
// Overview of operation
// [RULE1] a save copies pending settings into working and persistent copies
// [RULE2] apply updates only the working copy; power-up reloads it from persistent
// [RULE3] reading settings returns the working copy
// [RULE4] saved baud rate acts only after power cycle; default 38400
// [RULE5] sixteen mounting orientations, standard by default
// [RULE6] angles in degrees by default or in mils, 6400 per circle
// [RULE7] magnetic north by default; true north adds the declination
// [RULE8] heading filter used only in compass mode, not in fused attitude mode
// [RULE9] filter length 0, 4, 8, 16 or 32 taps; zero bypasses; default 32
// [RULE10] sliding window: once full, newest sample in, oldest dropped
// [RULE11] flush clears filter; valid after tap count new samples
// [RULE12] continuous mode waits sample delay seconds between sets; 0 means none
// [RULE13] polled mode answers each host request with one set
// [RULE14] gyro initialisation during first five seconds after power-up
`ifndef HFA_DEFINES_SVH
`define HFA_DEFINES_SVH

// ==========================================================
// register offsets
`define HFA_A_CTRL 8'h00
`define HFA_A_PEND_MODE 8'h04
`define HFA_A_PEND_DECL 8'h08
`define HFA_A_PEND_DLY 8'h0C
`define HFA_A_WORK_MODE 8'h10
`define HFA_A_WORK_DECL 8'h14
`define HFA_A_WORK_DLY 8'h18
`define HFA_A_STATUS 8'h1C

// ==========================================================
// control bits
`define HFA_CTRL_SAVE 0
`define HFA_CTRL_APPLY 1
`define HFA_CTRL_POLL 2

// ==========================================================
// reset values
`define HFA_BAUD_38400 4'h5
`define HFA_TAPS_MAX_CODE 3'h4
`define HFA_MODE_RST 16'h1005
`define HFA_CFG_RST {`HFA_MODE_RST, 16'h0000, 16'h0000}

// ==========================================================
// angles in sixteenths of a degree; mils = units * 10 / 9
`define HFA_CIRCLE_UNITS 17'sh01680
`define HFA_MILS_CIRCLE 6400
`define HFA_MILS_NUM 32'sd10
`define HFA_MILS_DEN 32'sd9

// ==========================================================
// timing
`define HFA_CLK_HZ 20000000
`define HFA_SEC_CYC (`HFA_CLK_HZ * 1)
`define HFA_INIT_S 16'h0005

`endif

// ---- verilog/hfa_pkg.sv ----
// types of the heading filter acquisition block
package hfa_pkg;

	typedef struct packed {
		logic fused;
		logic contMode;
		logic flush;
		logic [2:0] taps;
		logic northTrue;
		logic unitsMils;
		logic [3:0] mount;
		logic [3:0] baud;
	} hfa_mode_t;

	typedef struct packed {
		hfa_mode_t mode;
		logic [15:0] decl;
		logic [15:0] delay;
	} hfa_cfg_t;

	typedef struct packed {
		logic [15:0] heading;
		logic [15:0] pitch;
		logic [15:0] roll;
	} hfa_att_t;

	typedef enum logic [2:0] {
		S_INIT = 3'b000,
		S_IDLE = 3'b001,
		S_COLL = 3'b010,
		S_SEND = 3'b011,
		S_WAIT = 3'b100
	} hfa_state_t;

endpackage

// ---- verilog/hfa_window_mem.sv ----
// sample window memory with registered read data
`timescale 1ns/10ps
module hfa_window_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		rdata_q <= mem[raddr];
	end
endmodule

// ---- verilog/hfa_sec_tick.sv ----
// one-second tick generator with restart
`timescale 1ns/10ps
module hfa_sec_tick #(
	parameter int CYC = 20000000
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic restart,
	output logic tick_q
);
	logic [31:0] cnt_q;

	if (CYC < 2) begin : g_chk
		$error("hfa_sec_tick: CYC must be at least 2");
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || restart) begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (cnt_q == 32'(CYC - 1)) begin
			cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end
endmodule

// ---- verilog/hfa_top.sv ----
// heading filter acquisition: settings store, heading filter, output pacing
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "hfa_defines.svh"
module hfa_top import hfa_pkg::*; #(
	parameter int SEC_CYC = `HFA_SEC_CYC,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sampleValid,
	input wire hfa_att_t sampleIn,
	input wire hfa_cfg_t nvData,
	input wire logic nvBlank,
	output logic nvWrEn,
	output hfa_cfg_t nvWrData,
	output logic [3:0] baudSel,
	output logic [3:0] mountSel,
	output logic fusedMode,
	output logic initDone,
	output logic setValid,
	output hfa_att_t setData,
	input wire logic setReady
);
	if (DEPTH < 32 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("hfa_top: DEPTH must be a power of two of at least 32");
	end

	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// apb slave
	hfa_cfg_t pend_q, work_q;
	hfa_state_t state_q;
	logic bootLoad_q, pollPend_q, filtValid_q;
	logic setup, wrAcc, mapped, saveReq, applyReq, pollReq;
	logic [31:0] rdMux;

	assign setup = psel && !penable;
	assign wrAcc = psel && penable && pwrite && mapped;
	assign saveReq = wrAcc && paddr == `HFA_A_CTRL && pwdata[`HFA_CTRL_SAVE];
	assign applyReq = wrAcc && paddr == `HFA_A_CTRL && pwdata[`HFA_CTRL_APPLY];
	assign pollReq = wrAcc && paddr == `HFA_A_CTRL && pwdata[`HFA_CTRL_POLL];

	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h00000000;
		unique case (paddr)
			`HFA_A_CTRL: rdMux = {29'h0, pollPend_q, 2'h0};
			`HFA_A_PEND_MODE: rdMux = {16'h0, pend_q.mode};
			`HFA_A_PEND_DECL: rdMux = {16'h0, pend_q.decl};
			`HFA_A_PEND_DLY: rdMux = {16'h0, pend_q.delay};
			`HFA_A_WORK_MODE: rdMux = {16'h0, work_q.mode}; // RULE3
			`HFA_A_WORK_DECL: rdMux = {16'h0, work_q.decl}; // RULE3
			`HFA_A_WORK_DLY: rdMux = {16'h0, work_q.delay}; // RULE3
			`HFA_A_STATUS: rdMux = {23'h0, baudSel, state_q, filtValid_q,
				initDone};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rdMux;
				pslverr <= !mapped;
			end
		end
	end

	// ==========================================================
	// pending, working and persistent settings
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pend_q <= `HFA_CFG_RST;
		end else if (bootLoad_q) begin
			pend_q <= nvBlank ? `HFA_CFG_RST : nvData;
		end else if (wrAcc) begin
			unique case (paddr)
				`HFA_A_PEND_MODE: begin
					pend_q.mode <= pwdata[15:0];
					// illegal tap codes leave the length unchanged
					if (pwdata[12:10] > `HFA_TAPS_MAX_CODE) begin // RULE9
						pend_q.mode.taps <= pend_q.mode.taps;
					end
				end
				`HFA_A_PEND_DECL: pend_q.decl <= pwdata[15:0];
				`HFA_A_PEND_DLY: pend_q.delay <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			work_q <= `HFA_CFG_RST;
		end else if (bootLoad_q) begin
			work_q <= nvBlank ? `HFA_CFG_RST : nvData; // RULE2
		end else if (saveReq || applyReq) begin
			work_q <= pend_q; // RULE1 RULE2
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			nvWrEn <= 1'b0;
			nvWrData <= `HFA_CFG_RST;
		end else begin
			nvWrEn <= saveReq; // RULE1
			if (saveReq) begin
				nvWrData <= pend_q; // RULE1
			end
		end
	end

	// baud only follows the persistent copy at power-up
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bootLoad_q <= 1'b1;
			baudSel <= `HFA_BAUD_38400; // RULE4
		end else begin
			bootLoad_q <= 1'b0;
			if (bootLoad_q) begin
				baudSel <= nvBlank ? `HFA_BAUD_38400 : nvData.mode.baud; // RULE4
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mountSel <= 4'h0;
			fusedMode <= 1'b0;
		end else begin
			mountSel <= work_q.mode.mount; // RULE5
			fusedMode <= work_q.mode.fused;
		end
	end

	// ==========================================================
	// sliding window heading filter
	logic [5:0] tapsN, cnt_q, cntNext;
	logic [AW-1:0] ptr_q, ptrNext;
	logic [20:0] sum_q, sumNext, avg;
	logic [15:0] memRd;
	hfa_att_t samp_q;
	logic stage1_q, useFir, full, fltClr, resValid;
	logic [15:0] headRaw;

	always_comb begin
		unique case (work_q.mode.taps)
			3'h1: tapsN = 6'h04; // RULE9
			3'h2: tapsN = 6'h08;
			3'h3: tapsN = 6'h10;
			3'h4: tapsN = 6'h20;
			default: tapsN = 6'h00;
		endcase
	end

	assign useFir = !work_q.mode.fused && tapsN != 6'h00; // RULE8
	assign full = cnt_q == tapsN;
	assign sumNext = sum_q + {5'h00, samp_q.heading}
		- (full ? {5'h00, memRd} : 21'h000000); // RULE10
	assign cntNext = full ? cnt_q : cnt_q + 6'h01;
	assign ptrNext = ptr_q == AW'(tapsN - 6'h01) ? '0
		: ptr_q + AW'(1); // RULE10
	assign avg = sumNext >> (work_q.mode.taps + 3'h1);
	assign headRaw = useFir ? avg[15:0] : samp_q.heading; // RULE8
	assign resValid = stage1_q && (!useFir || cntNext == tapsN); // RULE11

	hfa_window_mem #(.WIDTH(16), .DEPTH(DEPTH)) u_mem (
		.core_clk(core_clk),
		.we(stage1_q && useFir && !fltClr),
		.waddr(ptr_q),
		.wdata(samp_q.heading),
		// read ahead so back to back samples see the oldest entry
		.raddr(stage1_q ? ptrNext : ptr_q),
		.rdata_q(memRd)
	);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stage1_q <= 1'b0;
			samp_q <= '0;
		end else begin
			stage1_q <= sampleValid;
			if (sampleValid) begin
				samp_q <= sampleIn;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || fltClr || !useFir) begin
			cnt_q <= 6'h00; // RULE11
			sum_q <= 21'h000000;
			ptr_q <= '0;
			filtValid_q <= 1'b0;
		end else if (stage1_q) begin
			cnt_q <= cntNext;
			sum_q <= sumNext;
			filtValid_q <= cntNext == tapsN;
			ptr_q <= ptrNext; // RULE10
		end
	end

	// ==========================================================
	// unit and reference conversion
	function automatic logic [15:0] toMils(input logic [15:0] v);
		logic signed [31:0] w;
		w = 32'(signed'(v)) * `HFA_MILS_NUM / `HFA_MILS_DEN;
		return w[15:0];
	endfunction

	logic signed [16:0] headRef;
	hfa_att_t conv;

	always_comb begin
		headRef = signed'({1'b0, headRaw});
		if (work_q.mode.northTrue) begin
			headRef = headRef + 17'(signed'(work_q.decl)); // RULE7
			if (headRef < 17'sh00000) begin
				headRef = headRef + `HFA_CIRCLE_UNITS;
			end else if (headRef >= `HFA_CIRCLE_UNITS) begin
				headRef = headRef - `HFA_CIRCLE_UNITS;
			end
		end
		conv.heading = headRef[15:0];
		conv.pitch = samp_q.pitch;
		conv.roll = samp_q.roll;
		if (work_q.mode.unitsMils) begin
			conv.heading = toMils(headRef[15:0]); // RULE6
			conv.pitch = toMils(samp_q.pitch); // RULE6
			conv.roll = toMils(samp_q.roll); // RULE6
		end
	end

	// ==========================================================
	// acquisition sequencer
	logic secTick, tickRst, trigger;
	logic [15:0] secCnt_q;

	assign trigger = work_q.mode.contMode || pollPend_q; // RULE13
	assign fltClr = bootLoad_q || saveReq || applyReq
		|| (state_q == S_IDLE && trigger && work_q.mode.flush); // RULE11
	assign tickRst = state_q == S_SEND && setReady;

	hfa_sec_tick #(.CYC(SEC_CYC)) u_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.restart(tickRst),
		.tick_q(secTick)
	);

	always_ff @(posedge core_clk) begin
		if (sys_rst || tickRst) begin
			secCnt_q <= 16'h0000;
		end else if (secTick && secCnt_q != 16'hFFFF) begin
			secCnt_q <= secCnt_q + 16'h0001;
		end
	end

	// a request arriving as the last one is taken stays pending
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pollPend_q <= 1'b0;
		end else if (pollReq && !work_q.mode.contMode) begin
			pollPend_q <= 1'b1; // RULE13
		end else if (state_q == S_IDLE || work_q.mode.contMode) begin
			pollPend_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= S_INIT;
			initDone <= 1'b0;
			setValid <= 1'b0;
			setData <= '0;
		end else begin
			unique case (state_q)
				S_INIT: begin
					if (secCnt_q == `HFA_INIT_S) begin // RULE14
						initDone <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_IDLE: begin
					if (trigger) begin
						state_q <= S_COLL;
					end
				end
				S_COLL: begin
					if (resValid) begin
						setData <= conv;
						setValid <= 1'b1;
						state_q <= S_SEND;
					end
				end
				S_SEND: begin
					if (setReady) begin
						setValid <= 1'b0;
						state_q <= work_q.mode.contMode ? S_WAIT : S_IDLE; // RULE12
					end
				end
				S_WAIT: begin
					if (secCnt_q >= work_q.delay) begin // RULE12
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_save_both: assert property ( // RULE1
		saveReq && !bootLoad_q |=> nvWrEn && nvWrData == work_q
			&& work_q == $past(pend_q))
		else $error("save did not fill both copies");

	chk_apply_work: assert property ( // RULE2
		applyReq && !saveReq && !bootLoad_q |=> !nvWrEn
			&& work_q == $past(pend_q))
		else $error("apply wrong");

	chk_read_work: assert property ( // RULE3
		setup && !pwrite && paddr == `HFA_A_WORK_MODE
			|=> prdata == {16'h0, $past(work_q.mode)})
		else $error("settings read not working copy");

	chk_baud_hold: assert property ( // RULE4
		!$past(bootLoad_q) |-> $stable(baudSel))
		else $error("baud changed after power-up");

	chk_taps_legal: assert property ( // RULE9
		work_q.mode.taps <= `HFA_TAPS_MAX_CODE)
		else $error("illegal tap code in use");

	chk_fir_window: assert property ( // RULE10
		(cnt_q <= tapsN) and (full && stage1_q && !fltClr && useFir
			|=> cnt_q == $past(tapsN)))
		else $error("window count out of range");

	chk_flush_clear: assert property ( // RULE11
		fltClr |=> cnt_q == 6'h00 && !filtValid_q)
		else $error("flush did not clear filter");

	chk_fir_bypass: assert property ( // RULE8
		work_q.mode.fused |-> cnt_q == 6'h00 || $past(!work_q.mode.fused))
		else $error("filter active in fused mode");

	chk_poll_one: assert property ( // RULE13
		state_q == S_SEND && setReady && !work_q.mode.contMode
			|=> state_q == S_IDLE && !setValid)
		else $error("polled set not single");

	chk_delay_wait: assert property ( // RULE12
		state_q == S_SEND && setReady && work_q.mode.contMode
			&& work_q.delay != 16'h0000 |=> state_q == S_WAIT [*2])
		else $error("sample delay skipped");

	chk_init_gate: assert property ( // RULE14
		setValid |-> initDone)
		else $error("set sent before gyro init");
endmodule

// ---- verification/hfa_host_model.sv ----
// host-side model: persistent store and consumer of measurement sets
`timescale 1ns/10ps
module hfa_host_model import hfa_pkg::*; (
	input wire logic core_clk,
	input wire logic nvWrEn,
	input wire hfa_cfg_t nvWrData,
	input wire logic setValid,
	input wire logic [3:0] lag,
	output hfa_cfg_t nvData,
	output logic nvBlank,
	output logic setReady
);
	logic [3:0] waitCnt;
	initial begin
		nvData = '0;
		nvBlank = 1'b1;
		setReady = 1'b0;
		waitCnt = 4'h0;
	end
	// store survives power cycles of the device
	always @(posedge core_clk) begin
		if (nvWrEn) begin
			nvData <= nvWrData;
			nvBlank <= 1'b0;
		end
	end
	// one acceptance per offered set, after lag cycles
	always @(posedge core_clk) begin
		setReady <= setValid && !setReady && waitCnt >= lag;
		waitCnt <= (setValid && !setReady) ? waitCnt + 4'h1 : 4'h0;
	end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the heading filter acquisition block
`timescale 1ns/10ps
`include "hfa_defines.svh"
module testbench import hfa_pkg::*;;
	localparam int SEC = 20;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sampleValid = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, lastErr, nvWrEn, nvBlank, setValid, setReady;
	logic fusedMode, initDone;
	logic [3:0] baudSel, mountSel;
	logic [3:0] lag = 4'h0;
	hfa_att_t sampleIn = '0;
	hfa_att_t setData;
	hfa_cfg_t nvData, nvWrData;
	int numErrors = 0;
	int totalChecks = 0;

	hfa_top #(.SEC_CYC(SEC), .DEPTH(32)) hfa_top_inst (.core_clk(core_clk),
		.sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sampleValid(sampleValid), .sampleIn(sampleIn),
		.nvData(nvData), .nvBlank(nvBlank), .nvWrEn(nvWrEn),
		.nvWrData(nvWrData), .baudSel(baudSel), .mountSel(mountSel),
		.fusedMode(fusedMode), .initDone(initDone), .setValid(setValid),
		.setData(setData), .setReady(setReady));
	hfa_host_model hfa_host_model_inst (.core_clk(core_clk), .nvWrEn(nvWrEn),
		.nvWrData(nvWrData), .setValid(setValid), .lag(lag), .nvData(nvData),
		.nvBlank(nvBlank), .setReady(setReady));

	initial begin
		forever #25 core_clk = ~core_clk;
	end

	// ==========================================
	// shared tasks
	task conclude;
		if (numErrors == 0 && totalChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task guard(input int n, input int m);
		if (n >= m) begin
			numErrors++;
			conclude;
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		guard(n, 20);
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(nm, e, rd);
	endtask

	task setMode(input logic [31:0] m, input logic [31:0] dc,
		input logic [31:0] dl);
		wr(`HFA_A_PEND_MODE, m);
		wr(`HFA_A_PEND_DECL, dc);
		wr(`HFA_A_PEND_DLY, dl);
		wr(`HFA_A_CTRL, 32'h2);
	endtask

	task smp(input logic [15:0] h, input logic [15:0] p, input logic [15:0] r);
		@(posedge core_clk);
		sampleValid <= 1'b1;
		sampleIn <= {h, p, r};
		@(posedge core_clk);
		sampleValid <= 1'b0;
	endtask

	task getSet(input logic [15:0] h, input logic [15:0] p,
		input logic [15:0] r);
		int n;
		for (n = 0; n < 100 && setValid !== 1'b1; n++)
			@(posedge core_clk);
		guard(n, 100);
		check("heading", h, setData.heading);
		check("pitch", p, setData.pitch);
		check("roll", r, setData.roll);
		for (n = 0; n < 50 && setValid === 1'b1; n++)
			@(posedge core_clk);
		guard(n, 50);
	endtask

	task single(input logic [31:0] m, input logic [31:0] dc,
		input logic [47:0] s, input logic [47:0] e);
		setMode(m, dc, 32'h0);
		wr(`HFA_A_CTRL, 32'h4);
		smp(s[47:32], s[31:16], s[15:0]);
		getSet(e[47:32], e[31:16], e[15:0]);
	endtask

	// ==========================================
	// scenarios
	task sDefaults;
		check("baudSel", 32'h5, baudSel);
		check("mountSel", 32'h0, mountSel);
		check("initDone", 32'h0, initDone);
		rdChk("workMode", `HFA_A_WORK_MODE, 32'h1005);
		rdChk("workDly", `HFA_A_WORK_DLY, 32'h0);
		wr(`HFA_A_PEND_MODE, 32'h1C35);
		rdChk("tapsIllegal", `HFA_A_PEND_MODE, 32'h1035);
		rdChk("unmapped", 8'h20, 32'h0);
		check("slverr", 32'h1, lastErr);
	endtask

	task sStore;
		setMode(32'h1036, 32'h0, 32'h0);
		rdChk("workApply", `HFA_A_WORK_MODE, 32'h1036);
		check("nvBlank", 32'h1, nvBlank);
		check("mountSel", 32'h3, mountSel);
		wr(`HFA_A_PEND_MODE, 32'h1048);
		rdChk("workRead", `HFA_A_WORK_MODE, 32'h1036);
		wr(`HFA_A_PEND_MODE, 32'h1037);
		wr(`HFA_A_CTRL, 32'h1);
		tick(2);
		check("nvMode", 32'h1037, nvData.mode);
		rdChk("workSave", `HFA_A_WORK_MODE, 32'h1037);
		check("baudSaved", 32'h5, baudSel);
		setMode(32'h1048, 32'h0, 32'h0);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		tick(2);
		rdChk("workPower", `HFA_A_WORK_MODE, 32'h1037);
		check("baudPower", 32'h7, baudSel);
	endtask

	task sInit;
		int n;
		tick(86);
		check("initEarly", 32'h0, initDone);
		for (n = 0; n < 40 && initDone !== 1'b1; n++)
			@(posedge core_clk);
		guard(n, 40);
		rdChk("status", `HFA_A_STATUS, 32'hE5);
	endtask

	task sFormats;
		single(32'h0105, 0, {16'd900, 16'hFFA6, 16'd45},
			{16'd1000, 16'hFF9C, 16'd50});
		single(32'h0205, 100, {16'd5700, 32'h0}, {16'd40, 32'h0});
		single(32'h0005, 100, {16'd320, 32'h0}, {16'd320, 32'h0});
		single(32'h8405, 0, {16'd160, 32'h0}, {16'd160, 32'h0});
		check("fusedMode", 32'h1, fusedMode);
	endtask

	task sSlide;
		lag <= 4'h3;
		setMode(32'h0405, 0, 0);
		wr(`HFA_A_CTRL, 32'h4);
		for (int i = 0; i < 4; i++)
			smp(16'(i * 16), 16'h0, 16'h0);
		getSet(16'd24, 16'h0, 16'h0);
		wr(`HFA_A_CTRL, 32'h4);
		smp(16'd80, 16'h0, 16'h0);
		getSet(16'd44, 16'h0, 16'h0);
		wr(`HFA_A_CTRL, 32'h4);
		smp(16'd96, 16'h0, 16'h0);
		getSet(16'd64, 16'h0, 16'h0);
		lag <= 4'h0;
	endtask

	task sFlush;
		setMode(32'h2405, 0, 0);
		wr(`HFA_A_CTRL, 32'h4);
		repeat (4) smp(16'd16, 16'h0, 16'h0);
		getSet(16'd16, 16'h0, 16'h0);
		wr(`HFA_A_CTRL, 32'h4);
		repeat (3) smp(16'd32, 16'h0, 16'h0);
		tick(3);
		check("earlySet", 32'h0, setValid);
		smp(16'd32, 16'h0, 16'h0);
		getSet(16'd32, 16'h0, 16'h0);
		smp(16'd32, 16'h0, 16'h0);
		tick(3);
		check("extraSet", 32'h0, setValid);
	endtask

	task sCont;
		int c;
		int acc;
		logic prev;
		acc = -1;
		prev = 1'b1;
		setMode(32'h4005, 0, 1);
		for (c = 0; c < 400; c++) begin
			@(posedge core_clk);
			sampleValid <= (c % 4 == 0);
			if (setValid === 1'b1 && prev === 1'b0 && acc >= 0)
				break;
			if (setValid === 1'b1 && setReady === 1'b1)
				acc = c;
			prev = setValid;
		end
		sampleValid <= 1'b0;
		guard(c, 400);
		check("gap", 32'h1, (c - acc >= SEC) && (c - acc <= SEC + 10));
	endtask

	initial begin
		tick(2);
		sys_rst <= 1'b0;
		tick(2);
		sDefaults;
		sStore;
		sInit;
		sFormats;
		sSlide;
		sFlush;
		sCont;
		conclude;
	end
endmodule
